// file: rtl/iep_params.svh
`ifndef IEP_PARAMS_SVH
`define IEP_PARAMS_SVH

`define IEP_DATA_W      8
`define IEP_DEPTH       8
`define IEP_PTR_W       3
`define IEP_CNT_W       4
`define IEP_PACKET_BYTE_COUNT_W      4
`define IEP_ADDR_W      2

`define IEP_ADDR_CTRL   2'h0
`define IEP_ADDR_STAT   2'h1
`define IEP_ADDR_PACKET_BYTE_COUNT   2'h2

`define IEP_CTRL_CLR    7
`define IEP_CTRL_OVR    6
`define IEP_CTRL_STL    3
`define IEP_CTRL_RDY    1
`define IEP_CTRL_EN     0

`define IEP_STAT_TGL    7
`define IEP_STAT_STALL  3
`define IEP_STAT_NACK   2
`define IEP_STAT_ERR    1
`define IEP_STAT_ACK    0

`define IEP_BYTE_ZERO   8'h00
`define IEP_CNT_ZERO    4'h0
`define IEP_CNT_ONE     4'h1
`define IEP_CNT_FULL    4'h8
`define IEP_PTR_ZERO    3'h0
`define IEP_PTR_ONE     3'h1
`define IEP_RSVD2       2'h0
`define IEP_RSVD3       3'h0
`define IEP_RSVD4       4'h0

`endif

// file: rtl/iep_pkg.sv
package iep_pkg;

  typedef enum logic [1:0] {
    IEP_RESP_NACK,
    IEP_RESP_STALL,
    IEP_RESP_DATA0,
    IEP_RESP_DATA1
  } iep_resp_t;

  typedef enum logic {
    IEP_IDLE,
    IEP_SEND
  } iep_state_t;

endpackage : iep_pkg

// file: rtl/iep_fifo_if.sv
`timescale 1ns/1ps
`include "iep_params.svh"

interface iep_fifo_if;
  logic                   push;
  logic                   pop;
  logic                   flush;
  logic [`IEP_DATA_W-1:0] wdata;
  logic [`IEP_DATA_W-1:0] rdata;
  logic                   empty;
  logic                   full;

  modport core  (output push, output pop, output flush, output wdata,
                 input rdata, input empty, input full);
  modport store (input push, input pop, input flush, input wdata,
                 output rdata, output empty, output full);
endinterface : iep_fifo_if

// file: rtl/iep_fifo.sv
`timescale 1ns/1ps
`include "iep_params.svh"

module iep_fifo (
  input wire logic clk_i,
  input wire logic rstn_i,
  iep_fifo_if.store f
);
  import iep_pkg::*;

  logic [`IEP_DATA_W-1:0] mem_q [0:`IEP_DEPTH-1];
  logic [`IEP_PTR_W-1:0]  wr_q;
  logic [`IEP_PTR_W-1:0]  rd_q;
  logic [`IEP_CNT_W-1:0]  cnt_q;
  logic [`IEP_CNT_W-1:0]  cnt_d;

  function automatic logic [`IEP_PTR_W-1:0] ptr_inc(
    input logic [`IEP_PTR_W-1:0] p);
    return p + `IEP_PTR_ONE;
  endfunction : ptr_inc

  // a push into a full store is dropped; the top flags it
  wire do_push = f.push & ~f.full;
  wire do_pop  = f.pop & ~f.empty;

  assign cnt_d = (do_push & ~do_pop) ? cnt_q + `IEP_CNT_ONE :
                 (do_pop & ~do_push) ? cnt_q - `IEP_CNT_ONE : cnt_q;

  assign f.rdata = mem_q[rd_q];
  assign f.empty = (cnt_q == `IEP_CNT_ZERO); // [R18]
  assign f.full  = (cnt_q == `IEP_CNT_FULL); // [R19] [R22]

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || f.flush)
    begin
      wr_q  <= `IEP_PTR_ZERO; // [R1]
      rd_q  <= `IEP_PTR_ZERO; // [R1]
      cnt_q <= `IEP_CNT_ZERO;
    end
    else
    begin
      if (do_push)
        wr_q <= ptr_inc(wr_q);
      if (do_pop)
        rd_q <= ptr_inc(rd_q);
      cnt_q <= cnt_d;
    end
  end

  // data only, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (do_push)
      mem_q[wr_q] <= f.wdata;
  end

  a_flush_empties: assert property (@(posedge clk_i) disable iff (!rstn_i)
    f.flush |=> f.empty && !f.full) // [R2]
    else $error("store not empty after flush");

  a_fill_to_full: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (do_push && !do_pop && !f.flush &&
     cnt_q == (`IEP_CNT_FULL - `IEP_CNT_ONE)) |=> f.full) // [R19]
    else $error("eighth byte did not make the store full");

endmodule : iep_fifo

// file: rtl/iep_tx_endpoint.sv
`timescale 1ns/1ps
`include "iep_params.svh"

// Behaviour
// R1: clear bit resets FIFO pointers and flags
// R2: clear self-clears; empty one, others zero
// R3: microcontroller clears FIFO after over/under-run
// R4: toggle writable only while override enabled
// R5: stall request answers next IN with STALL
// R6: byte count write sets packet ready
// R7: ready drops on ACK status or clear
// R8: not ready answers IN with NACK
// R9: stall request replaces NACK with STALL
// R10: endpoint enable needed for any operation; the code uses it only to gate IN token acceptance
// R11: toggle picks DATA0 or DATA1 PID
// R12: toggle inverts after each successful IN
// R13: stall status rewritten per valid IN
// R14: NACK status rewritten per valid IN
// R15: error status rewritten per valid IN
// R16: host ACK sets ACK status, interrupt
// R17: microcontroller clears ACK to drop interrupt
// R18: empty flag tracks no bytes held
// R19: full flag tracks eight bytes held
// R20: pop from empty FIFO sets under-run
// R21: write to full FIFO sets over-run
// R22: FIFO holds eight bytes at most
// R23: byte count never decrements while sending
// R24: masked interrupt output holds until cleared
// R25: packet carries byte count bytes in order
module iep_tx_endpoint (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   reg_we_i,
  input  wire logic [`IEP_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`IEP_DATA_W-1:0] reg_wdata_i,
  input  wire logic                   fifo_wr_i,
  input  wire logic [`IEP_DATA_W-1:0] fifo_wdata_i,
  input  wire logic                   in_tok_i,
  input  wire logic                   byte_req_i,
  input  wire logic                   txn_ack_i,
  input  wire logic                   txn_err_i,
  input  wire logic                   irq_mask_i,
  output logic [`IEP_DATA_W-1:0]      ctrl_o,
  output logic [`IEP_DATA_W-1:0]      status_o,
  output logic [`IEP_DATA_W-1:0]      flags_o,
  output logic [`IEP_DATA_W-1:0]      byte_count_o,
  output logic                        resp_valid_o,
  output iep_pkg::iep_resp_t          resp_kind_o,
  output logic [`IEP_PACKET_BYTE_COUNT_W-1:0]      resp_len_o,
  output logic                        byte_valid_o,
  output logic [`IEP_DATA_W-1:0]      byte_o,
  output logic                        byte_last_o,
  output logic                        tx_int_o,
  output logic                        irq_o
);
  import iep_pkg::*;

  iep_fifo_if fifo ();

  iep_fifo u_fifo (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .f      (fifo.store)
  );

  iep_state_t              state_q;
  logic                    clr_q;
  logic                    ovr_q;
  logic                    stl_q;
  logic                    rdy_q;
  logic                    en_q;
  logic                    tgl_q;
  logic                    st_stall_q;
  logic                    st_nack_q;
  logic                    st_err_q;
  logic                    st_ack_q;
  logic                    fifo_underrun_flag_q;
  logic                    fifo_overrun_flag_q;
  logic [`IEP_PACKET_BYTE_COUNT_W-1:0]  packet_byte_count_q;
  logic [`IEP_PACKET_BYTE_COUNT_W-1:0]  sent_q;
  logic                    resp_valid_q;
  iep_resp_t               resp_kind_q;
  logic [`IEP_PACKET_BYTE_COUNT_W-1:0]  resp_len_q;
  logic                    byte_valid_q;
  logic [`IEP_DATA_W-1:0]  byte_q;
  logic                    byte_last_q;

  // register write decode
  wire ctrl_we = reg_we_i & (reg_addr_i == `IEP_ADDR_CTRL);
  wire stat_we = reg_we_i & (reg_addr_i == `IEP_ADDR_STAT);
  wire packet_byte_count_we = reg_we_i & (reg_addr_i == `IEP_ADDR_PACKET_BYTE_COUNT);
  wire clr_req = ctrl_we & reg_wdata_i[`IEP_CTRL_CLR];

  // token handling, only from idle and only while enabled
  wire in_idle   = (state_q == IEP_IDLE);
  wire in_send   = (state_q == IEP_SEND);
  wire tok_take  = in_idle & in_tok_i & en_q; // [R10]
  wire ans_stall = tok_take & stl_q; // [R5] [R9]
  wire ans_nack  = tok_take & ~stl_q & ~rdy_q; // [R8]
  wire ans_data  = tok_take & ~stl_q & rdy_q;

  // byte delivery stops at the byte count
  wire more_left = (sent_q != packet_byte_count_q);
  wire pop_try   = in_send & byte_req_i & more_left & ~clr_q; // [R25]
  wire fifo_underrun_flag_ev   = pop_try & fifo.empty; // [R20]
  wire fifo_overrun_flag_ev   = fifo_wr_i & fifo.full & ~clr_q; // [R21]

  // ack wins when the link reports both in one cycle
  wire ack_ev    = in_send & txn_ack_i;
  wire err_ev    = in_send & txn_err_i & ~txn_ack_i;
  wire send_done = ack_ev | err_ev;

  assign fifo.push  = fifo_wr_i & ~clr_q;
  assign fifo.pop   = pop_try;
  assign fifo.flush = clr_q; // [R1]
  assign fifo.wdata = fifo_wdata_i;

  wire       sent_last = ((sent_q + `IEP_CNT_ONE) == packet_byte_count_q);
  iep_resp_t data_pid;
  assign data_pid = tgl_q ? IEP_RESP_DATA1 : IEP_RESP_DATA0; // [R11]

  // clear bit lives one cycle: the flush cycle
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      clr_q <= 1'b0;
    else
      clr_q <= clr_req; // [R2]
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      ovr_q <= 1'b0;
      stl_q <= 1'b0;
      en_q  <= 1'b0;
    end
    else if (ctrl_we)
    begin
      ovr_q <= reg_wdata_i[`IEP_CTRL_OVR];
      stl_q <= reg_wdata_i[`IEP_CTRL_STL];
      en_q  <= reg_wdata_i[`IEP_CTRL_EN];
    end
  end

  // automatic clears outrank every write source
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      rdy_q <= 1'b0;
    else if (clr_req || ack_ev)
      rdy_q <= 1'b0; // [R7]
    else if (packet_byte_count_we)
      rdy_q <= 1'b1; // [R6]
    else if (ctrl_we)
      rdy_q <= reg_wdata_i[`IEP_CTRL_RDY];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      packet_byte_count_q <= `IEP_CNT_ZERO;
    else if (packet_byte_count_we)
      packet_byte_count_q <= reg_wdata_i[`IEP_PACKET_BYTE_COUNT_W-1:0]; // [R23]
  end

  // the hardware flip outranks a same-cycle override write
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      tgl_q <= 1'b0;
    else if (ack_ev)
      tgl_q <= ~tgl_q; // [R12]
    else if (stat_we && ovr_q)
      tgl_q <= reg_wdata_i[`IEP_STAT_TGL]; // [R4]
  end

  // outcome bits rewritten at the end of each valid IN
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st_stall_q <= 1'b0;
      st_nack_q  <= 1'b0;
      st_err_q   <= 1'b0;
    end
    else if (ans_stall || ans_nack || send_done)
    begin
      st_stall_q <= ans_stall; // [R13]
      st_nack_q  <= ans_nack; // [R14]
      st_err_q   <= err_ev; // [R15]
    end
  end

  // set wins over the software clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      st_ack_q <= 1'b0;
    else if (ack_ev)
      st_ack_q <= 1'b1; // [R16]
    else if (stat_we)
      st_ack_q <= reg_wdata_i[`IEP_STAT_ACK]; // [R17]
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      fifo_underrun_flag_q <= 1'b0;
      fifo_overrun_flag_q <= 1'b0;
    end
    else
    begin
      fifo_underrun_flag_q <= fifo_underrun_flag_ev | (fifo_underrun_flag_q & ~clr_q); // [R20] [R2]
      fifo_overrun_flag_q <= fifo_overrun_flag_ev | (fifo_overrun_flag_q & ~clr_q); // [R21] [R2]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      state_q <= IEP_IDLE;
    else
    begin
      case (state_q)
        IEP_IDLE:
          if (ans_data)
            state_q <= IEP_SEND;
        IEP_SEND:
          if (send_done)
            state_q <= IEP_IDLE;
        default:
          state_q <= IEP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || ans_data)
      sent_q <= `IEP_CNT_ZERO;
    else if (pop_try)
      sent_q <= sent_q + `IEP_CNT_ONE;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      resp_valid_q <= 1'b0;
      resp_kind_q  <= IEP_RESP_NACK;
      resp_len_q   <= `IEP_CNT_ZERO;
    end
    else
    begin
      resp_valid_q <= tok_take;
      if (tok_take)
      begin
        resp_kind_q <= ans_stall ? IEP_RESP_STALL :
                       ans_nack  ? IEP_RESP_NACK : data_pid;
        resp_len_q  <= ans_data ? packet_byte_count_q : `IEP_CNT_ZERO;
      end
    end
  end

  // an under-run byte goes out as zero; the flag tells software
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      byte_valid_q <= 1'b0;
      byte_q       <= `IEP_BYTE_ZERO;
      byte_last_q  <= 1'b0;
    end
    else
    begin
      byte_valid_q <= pop_try;
      if (pop_try)
      begin
        byte_q      <= fifo.empty ? `IEP_BYTE_ZERO : fifo.rdata; // [R25]
        byte_last_q <= sent_last;
      end
    end
  end

  assign ctrl_o       = {clr_q, ovr_q, `IEP_RSVD2, stl_q, 1'b0, rdy_q, en_q};
  assign status_o     = {tgl_q, `IEP_RSVD3, st_stall_q, st_nack_q,
                         st_err_q, st_ack_q};
  assign flags_o      = {`IEP_RSVD4, fifo.empty, fifo.full, fifo_underrun_flag_q, fifo_overrun_flag_q};
  assign byte_count_o = {`IEP_RSVD4, packet_byte_count_q};
  assign resp_valid_o = resp_valid_q;
  assign resp_kind_o  = resp_kind_q;
  assign resp_len_o   = resp_len_q;
  assign byte_valid_o = byte_valid_q;
  assign byte_o       = byte_q;
  assign byte_last_o  = byte_last_q;
  assign tx_int_o     = st_ack_q | fifo_underrun_flag_q | fifo_overrun_flag_q;
  assign irq_o        = tx_int_o & irq_mask_i; // [R24]

  a_clear_self: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    clr_q |=> !clr_q || $past(clr_req))
    else $error("clear bit did not self-clear");

  a_clear_flags: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    (clr_q && !fifo_wr_i) |=> flags_o == 8'h08)
    else $error("flags wrong after fifo clear");

  a_count_ready: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R6]
    (packet_byte_count_we && !clr_req && !ack_ev) |=> rdy_q)
    else $error("byte count write did not set ready");

  a_ack_ready: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R7]
    (ack_ev || clr_req) |=> !rdy_q && (st_ack_q || !$past(ack_ev)))
    else $error("ready still set after ack or clear");

  a_nack_answer: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R8]
    (tok_take && !stl_q && !rdy_q) |=> resp_valid_o &&
      resp_kind_o == IEP_RESP_NACK && st_nack_q && !st_stall_q)
    else $error("missing nack answer");

  a_stall_answer: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R5]
    (tok_take && stl_q) |=> resp_valid_o &&
      resp_kind_o == IEP_RESP_STALL && st_stall_q ##1 in_idle)
    else $error("missing stall answer");

  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R10]
    !en_q |=> !resp_valid_o)
    else $error("disabled endpoint answered");

  a_toggle_flip: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R12]
    ack_ev |=> tgl_q != $past(tgl_q) && st_ack_q && tx_int_o)
    else $error("toggle not inverted after success");

  a_toggle_lock: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R4]
    (!ovr_q && !ack_ev) |=> $stable(tgl_q))
    else $error("toggle changed without override");

  a_count_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R23]
    !packet_byte_count_we |=> $stable(packet_byte_count_q))
    else $error("byte count changed without a write");

  a_byte_limit: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R25]
    (byte_valid_o && byte_last_o) |-> sent_q == packet_byte_count_q)
    else $error("last byte flagged at wrong count");

endmodule : iep_tx_endpoint

// file: bench/iep_sie_model.sv
`timescale 1ns/1ps
`include "iep_params.svh"

module iep_sie_model (
  input  wire logic                   clk_i,
  input  wire logic                   resp_valid_i,
  input  wire iep_pkg::iep_resp_t     resp_kind_i,
  input  wire logic [`IEP_PACKET_BYTE_COUNT_W-1:0] resp_len_i,
  input  wire logic                   byte_valid_i,
  input  wire logic [`IEP_DATA_W-1:0] byte_i,
  input  wire logic                   byte_last_i,
  output logic                        in_tok_o,
  output logic                        byte_req_o,
  output logic                        txn_ack_o,
  output logic                        txn_err_o
);
  import iep_pkg::*;
  logic [`IEP_DATA_W-1:0] got [8];
  logic [`IEP_DATA_W-1:0] lastmask;
  iep_resp_t              kind;
  logic [`IEP_PACKET_BYTE_COUNT_W-1:0] len;
  logic                   seen;

  initial
  begin
    in_tok_o = 1'b0;
    byte_req_o = 1'b0;
    txn_ack_o = 1'b0;
    txn_err_o = 1'b0;
  end

  // one token; answer and bytes come a fixed cycle after each request
  task automatic token(input int nreq, input logic fail);
    int k;
    @(posedge clk_i);
    in_tok_o <= 1'b1;
    @(posedge clk_i);
    in_tok_o <= 1'b0;
    @(posedge clk_i);
    seen = resp_valid_i;
    kind = resp_kind_i;
    len = resp_len_i;
    lastmask = 8'h00;
    if (seen !== 1'b1 || kind inside {IEP_RESP_NACK, IEP_RESP_STALL})
      return;
    for (k = 0; k < nreq; k++)
    begin
      @(posedge clk_i);
      byte_req_o <= 1'b1;
      @(posedge clk_i);
      byte_req_o <= 1'b0;
      @(posedge clk_i);
      testbench.cmp(8'(byte_valid_i), 8'h01);
      got[k] = byte_i;
      lastmask[k] = byte_last_i;
    end
    // host either acknowledges or the packet fails on the wire
    @(posedge clk_i);
    txn_ack_o <= !fail;
    txn_err_o <= fail;
    @(posedge clk_i);
    txn_ack_o <= 1'b0;
    txn_err_o <= 1'b0;
  endtask : token
endmodule : iep_sie_model

// file: bench/testbench.sv
`timescale 1ns/1ps
`include "iep_params.svh"

module testbench;
  import iep_pkg::*;
  logic       clk_i, rstn_i, reg_we_i, fifo_wr_i, irq_mask_i;
  logic [1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, fifo_wdata_i;
  logic       in_tok_i, byte_req_i, txn_ack_i, txn_err_i;
  logic [7:0] ctrl_o, status_o, flags_o, byte_count_o, byte_o;
  logic       resp_valid_o, byte_valid_o, byte_last_o, tx_int_o, irq_o;
  iep_resp_t  resp_kind_o;
  logic [3:0] resp_len_o;
  int         n_errors, n_compared, i;

  iep_tx_endpoint u_iep_tx_endpoint (.clk_i, .rstn_i, .reg_we_i,
    .reg_addr_i, .reg_wdata_i, .fifo_wr_i, .fifo_wdata_i, .in_tok_i,
    .byte_req_i, .txn_ack_i, .txn_err_i, .irq_mask_i, .ctrl_o, .status_o,
    .flags_o, .byte_count_o, .resp_valid_o, .resp_kind_o, .resp_len_o,
    .byte_valid_o, .byte_o, .byte_last_o, .tx_int_o, .irq_o);

  iep_sie_model u_iep_sie_model (.clk_i, .resp_valid_i(resp_valid_o),
    .resp_kind_i(resp_kind_o), .resp_len_i(resp_len_o),
    .byte_valid_i(byte_valid_o), .byte_i(byte_o),
    .byte_last_i(byte_last_o), .in_tok_o(in_tok_i),
    .byte_req_o(byte_req_i), .txn_ack_o(txn_ack_i), .txn_err_o(txn_err_i));

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic cmpk(input iep_resp_t g, input iep_resp_t e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmpk

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic push(input logic [7:0] d);
    @(posedge clk_i);
    fifo_wr_i <= 1'b1;
    fifo_wdata_i <= d;
    @(posedge clk_i);
    fifo_wr_i <= 1'b0;
  endtask : push

  task automatic t_reset();
    cmp(ctrl_o, 8'h00);
    cmp(status_o, 8'h00);
    cmp(flags_o, 8'h08);
    cmp(8'(irq_o), 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_handshake();
    u_iep_sie_model.token(0, 1'b0);
    cmp(8'(u_iep_sie_model.seen), 8'h00);
    wr(`IEP_ADDR_CTRL, 8'h01);
    u_iep_sie_model.token(0, 1'b0);
    cmpk(u_iep_sie_model.kind, IEP_RESP_NACK);
    cmp(status_o, 8'h04);
    wr(`IEP_ADDR_CTRL, 8'h09);
    u_iep_sie_model.token(0, 1'b0);
    cmpk(u_iep_sie_model.kind, IEP_RESP_STALL);
    cmp(status_o, 8'h08);
    wr(`IEP_ADDR_CTRL, 8'h01);
    $display("test handshake done");
  endtask : t_handshake

  task automatic t_data();
    push(8'hA1);
    push(8'hB2);
    push(8'hC3);
    wr(`IEP_ADDR_PACKET_BYTE_COUNT, 8'h03);
    settle();
    cmp(ctrl_o, 8'h03);
    u_iep_sie_model.token(3, 1'b0);
    cmpk(u_iep_sie_model.kind, IEP_RESP_DATA0);
    cmp(8'(u_iep_sie_model.len), 8'h03);
    for (i = 0; i < 3; i++)
      cmp(u_iep_sie_model.got[i], 8'hA1 + 8'(i) * 8'h11);
    cmp(u_iep_sie_model.lastmask, 8'h04);
    settle();
    cmp(status_o, 8'h81);
    cmp(ctrl_o, 8'h01);
    cmp(byte_count_o, 8'h03);
    cmp(8'(irq_o), 8'h01);
    @(posedge clk_i);
    irq_mask_i <= 1'b0;
    settle();
    cmp(8'(irq_o), 8'h00);
    cmp(8'(tx_int_o), 8'h01);
    @(posedge clk_i);
    irq_mask_i <= 1'b1;
    wr(`IEP_ADDR_STAT, 8'h00);
    settle();
    cmp(status_o, 8'h80);
    cmp(8'(irq_o), 8'h00);
    $display("test data done");
  endtask : t_data

  task automatic t_overrun();
    for (i = 0; i < 9; i++)
      push(8'(i));
    settle();
    cmp(flags_o, 8'h05);
    cmp(8'(tx_int_o), 8'h01);
    wr(`IEP_ADDR_CTRL, 8'h81);
    settle();
    cmp(ctrl_o, 8'h01);
    cmp(flags_o, 8'h08);
    cmp(8'(tx_int_o), 8'h00);
    push(8'h77);
    wr(`IEP_ADDR_PACKET_BYTE_COUNT, 8'h01);
    u_iep_sie_model.token(1, 1'b0);
    cmpk(u_iep_sie_model.kind, IEP_RESP_DATA1);
    cmp(u_iep_sie_model.got[0], 8'h77);
    cmp(u_iep_sie_model.lastmask, 8'h01);
    wr(`IEP_ADDR_STAT, 8'h00);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_underrun();
    wr(`IEP_ADDR_CTRL, 8'h41);
    wr(`IEP_ADDR_STAT, 8'h80);
    settle();
    cmp(status_o, 8'h80);
    push(8'h5A);
    wr(`IEP_ADDR_PACKET_BYTE_COUNT, 8'h02);
    u_iep_sie_model.token(2, 1'b1);
    cmp(u_iep_sie_model.got[1], 8'h00);
    cmp(u_iep_sie_model.lastmask, 8'h02);
    settle();
    cmp(flags_o, 8'h0A);
    cmp(8'(tx_int_o), 8'h01);
    cmp(status_o, 8'h82);
    cmp(ctrl_o, 8'h43);
    wr(`IEP_ADDR_CTRL, 8'hC1);
    settle();
    cmp(ctrl_o, 8'h41);
    cmp(flags_o, 8'h08);
    cmp(8'(tx_int_o), 8'h00);
    $display("test underrun done");
  endtask : t_underrun

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    rstn_i = 1'b0;
    reg_we_i = 1'b0;
    reg_addr_i = 2'h0;
    reg_wdata_i = 8'h00;
    fifo_wr_i = 1'b0;
    fifo_wdata_i = 8'h00;
    irq_mask_i = 1'b1;
    n_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle();
    t_reset();
    t_handshake();
    t_data();
    t_overrun();
    t_underrun();
    give_verdict();
  end
endmodule : testbench
